// *** design/stopwatch_pkg.sv ***
package stopwatch_pkg;
  // register offsets
  localparam logic [7:0] ALARM_FIRST_OFFSET    = 8'h08;
  localparam logic [7:0] ALARM_LAST_OFFSET     = 8'h0f;
  localparam logic [7:0] ALARM_ENABLES_OFFSET  = 8'h10;
  localparam logic [7:0] PIN_A_ENABLES_OFFSET  = 8'h29;
  localparam logic [7:0] PIN_B_ENABLES_OFFSET  = 8'h2a;
  localparam logic [7:0] COUNTDOWN_OFFSET      = 8'h2d;

  // alarm enable field positions
  localparam int ALM2_UPPER_HOURS_BIT = 7;
  localparam int ALM2_LOWER_HOURS_BIT = 6;
  localparam int ALM2_MINUTES_BIT     = 5;
  localparam int ALM1_TOP_HOURS_BIT   = 4;
  localparam int ALM1_MID_HOURS_BIT   = 3;
  localparam int ALM1_LOW_HOURS_BIT   = 2;
  localparam int ALM1_MINUTES_BIT     = 1;
  localparam int ALM1_SECONDS_BIT     = 0;
  localparam logic [7:0] ALARM_ENABLES_RESET = 8'h00;

  // interrupt enable field positions in the pin a / pin b registers
  localparam int IRQ_ALARM1_BIT    = 4;
  localparam int IRQ_ALARM2_BIT    = 3;
  localparam int IRQ_COUNTDOWN_BIT = 2;
  localparam logic [7:0] IRQ_ENABLES_RESET = 8'h00;

  // countdown register layout
  localparam int CD_REPEAT_BIT = 7;
  localparam int CD_COUNT_MSB  = 6;
  localparam int CD_COUNT_LSB  = 2;
  localparam int CD_STEP_MSB   = 1;
  localparam int CD_STEP_LSB   = 0;
  localparam logic       CD_REPEAT_RESET = 1'b0;
  localparam logic [4:0] CD_COUNT_RESET  = 5'h00;
  localparam logic [1:0] CD_STEP_RESET   = 2'h0;
  localparam logic [7:0] ALARM_BYTE_RESET = 8'h00;

  // oscillator timebase: the finest step is a sixteenth second
  localparam int OSC_HZ          = 32768;
  localparam int FINEST_STEP_DIV = 16;
  localparam int OSC_PER_TICK    = OSC_HZ / FINEST_STEP_DIV;
  localparam logic [10:0] PRESC_LAST = 11'(OSC_PER_TICK - 1);

  typedef enum logic [1:0] {
    STEP_4S       = 2'h0,
    STEP_1S       = 2'h1,
    STEP_QUARTER  = 2'h2,
    STEP_SIXTEENTH = 2'h3
  } step_sel_t;

  // last sixteenth-second tick of each step, one less than the ticks in it
  localparam logic [5:0] TICKS_4S        = 6'(4 * FINEST_STEP_DIV - 1);
  localparam logic [5:0] TICKS_1S        = 6'(FINEST_STEP_DIV - 1);
  localparam logic [5:0] TICKS_QUARTER   = 6'(FINEST_STEP_DIV / 4 - 1);
  localparam logic [5:0] TICKS_SIXTEENTH = 6'h00;

  // implemented bits of each bcd alarm byte
  localparam logic [7:0] SEC_MIN_MASK = 8'h7f;
  localparam logic [7:0] HOURS_MASK   = 8'hff;
endpackage

// *** design/countdown_if.sv ***
`timescale 1ns/1ps
interface countdown_if;
  logic       osc_edge;
  logic       load_req;
  logic [4:0] load_value;
  logic       repeat_mode;
  logic [1:0] step_sel;
  logic [4:0] count;
  logic       expire;

  modport ctl  (output osc_edge, output load_req, output load_value, output repeat_mode,
                output step_sel, input count, input expire);
  modport unit (input osc_edge, input load_req, input load_value, input repeat_mode,
                input step_sel, output count, output expire);
endinterface

// *** design/countdown_unit.sv ***
`timescale 1ns/1ps
module countdown_unit
  import stopwatch_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   rst_b,
  countdown_if.unit   cd
);

  logic [10:0] presc_reg;
  logic [5:0]  step_cnt_reg;
  logic        pend_reg;
  logic [4:0]  pend_val_reg;
  logic [4:0]  reload_reg;
  logic [4:0]  count_reg;
  logic        expire_reg;
  logic        sixteenth;
  logic        step_tick;
  logic        apply_load;

  function automatic logic [5:0] step_last(input logic [1:0] sel);
    case (step_sel_t'(sel))
      STEP_4S:      step_last = TICKS_4S;
      STEP_1S:      step_last = TICKS_1S;
      STEP_QUARTER: step_last = TICKS_QUARTER;
      default:      step_last = TICKS_SIXTEENTH;
    endcase
  endfunction

  // free-running timebase, never restarted by a load
  assign sixteenth  = cd.osc_edge && (presc_reg == PRESC_LAST);
  assign step_tick  = sixteenth && (step_cnt_reg >= step_last(cd.step_sel));
  assign apply_load = cd.osc_edge && pend_reg;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      presc_reg <= 11'h000;
    end else if (cd.osc_edge) begin
      presc_reg <= (presc_reg == PRESC_LAST) ? 11'h000 : presc_reg + 11'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      step_cnt_reg <= 6'h00;
    end else if (sixteenth) begin
      step_cnt_reg <= step_tick ? 6'h00 : step_cnt_reg + 6'h01;
    end
  end

  // write held until the next oscillator edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg     <= 1'b0;
      pend_val_reg <= CD_COUNT_RESET;
    end else if (cd.load_req) begin
      pend_reg     <= 1'b1;
      pend_val_reg <= cd.load_value;
    end else if (cd.osc_edge) begin
      pend_reg     <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg  <= CD_COUNT_RESET;
      reload_reg <= CD_COUNT_RESET;
      expire_reg <= 1'b0;
    end else begin
      expire_reg <= 1'b0;
      if (apply_load) begin
        count_reg  <= pend_val_reg;
        reload_reg <= pend_val_reg;
      end else if (step_tick && count_reg != 5'h00) begin
        if (count_reg == 5'h01) begin
          expire_reg <= 1'b1;
          count_reg  <= cd.repeat_mode ? reload_reg : 5'h00;
        end else begin
          count_reg <= count_reg - 5'h01;
        end
      end
    end
  end

  assign cd.count  = count_reg;
  assign cd.expire = expire_reg;

  sequence s_load_taken;
    cd.osc_edge && pend_reg;
  endsequence

  a_load_takes_effect: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_load_taken |=> (count_reg == $past(pend_val_reg)))
    else $error("countdown load not applied at oscillator edge");

  a_single_shot_halt: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (step_tick && count_reg == 5'h01 && !cd.repeat_mode && !apply_load) |=> (count_reg == 5'h00 && expire_reg))
    else $error("single shot countdown did not stop at zero");

  a_stopped_silent: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (count_reg == 5'h00 && !pend_reg) |=> !expire_reg)
    else $error("stopped countdown expired");

endmodule // countdown_unit

// *** design/stopwatch_alarm_watchdog.sv ***
`timescale 1ns/1ps
module stopwatch_alarm_watchdog
  import stopwatch_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       osc_clk_pin,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       elapsed_time_mode_select,
  input  wire logic       time_inc,
  input  wire logic [7:0] time_sec,
  input  wire logic [7:0] time_min,
  input  wire logic [7:0] time_hr_low,
  input  wire logic [7:0] time_hr_mid,
  input  wire logic [7:0] time_hr_top,
  input  wire logic       alarm1_flag_clear,
  input  wire logic       alarm2_flag_clear,
  input  wire logic       countdown_flag_clear,
  input  wire logic       pin_a_pulse_mode,
  input  wire logic       pin_b_pulse_mode,
  output logic            first_alarm_flag,
  output logic            second_alarm_flag,
  output logic            countdown_expired_flag,
  output logic            irq_pin_a_n,
  output logic            irq_pin_b_n
);

  logic [7:0] alarm_byte_reg [0:7];
  logic [7:0] alarm_field_enables_reg;
  logic [7:0] pin_a_irq_enables_reg;
  logic [7:0] pin_b_irq_enables_reg;
  logic       countdown_repeat_select_reg;
  logic [1:0] countdown_step_select_reg;
  logic       load_req_reg;
  logic [4:0] load_value_reg;
  logic [7:0] reg_rdata_reg;
  logic       osc_meta_reg;
  logic       osc_sync_reg;
  logic       osc_prev_reg;
  logic       first_alarm_flag_reg;
  logic       second_alarm_flag_reg;
  logic       countdown_expired_flag_reg;
  logic       irq_pin_a_n_reg;
  logic       irq_pin_b_n_reg;
  logic       irq_pin_a_n_next;
  logic       irq_pin_b_n_next;
  logic       alarm1_hit;
  logic       alarm2_hit;
  logic [2:0] events;
  logic [2:0] flags;
  logic [2:0] pin_a_en;
  logic [2:0] pin_b_en;

  countdown_if cd ();

  function automatic logic field_ok(input logic en, input logic [7:0] set, input logic [7:0] now,
                                    input logic [7:0] mask);
    field_ok = !en || ((set & mask) == (now & mask));
  endfunction

  function automatic logic is_alarm_addr(input logic [7:0] a);
    is_alarm_addr = (a >= ALARM_FIRST_OFFSET) && (a <= ALARM_LAST_OFFSET);
  endfunction

  function automatic logic irq_level_n(input logic pulse_mode, input logic [2:0] ev,
                                       input logic [2:0] fl, input logic [2:0] en);
    irq_level_n = pulse_mode ? ~|(ev & en) : ~|(fl & en);
  endfunction

  // oscillator pin passes two flops before the edge detector
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      osc_meta_reg <= osc_clk_pin;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
    end
  end

  assign cd.osc_edge    = osc_sync_reg && !osc_prev_reg;
  assign cd.load_req    = load_req_reg;
  assign cd.load_value  = load_value_reg;
  assign cd.repeat_mode = countdown_repeat_select_reg;
  assign cd.step_sel    = countdown_step_select_reg;

  countdown_unit u_countdown (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .cd      (cd)
  );

  // register writes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) begin
        alarm_byte_reg[i] <= ALARM_BYTE_RESET;
      end
    end else if (reg_wr && is_alarm_addr(reg_addr)) begin
      alarm_byte_reg[3'(reg_addr - ALARM_FIRST_OFFSET)] <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_field_enables_reg <= ALARM_ENABLES_RESET;
    end else if (reg_wr && reg_addr == ALARM_ENABLES_OFFSET) begin
      alarm_field_enables_reg <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_a_irq_enables_reg <= IRQ_ENABLES_RESET;
      pin_b_irq_enables_reg <= IRQ_ENABLES_RESET;
    end else if (reg_wr) begin
      if (reg_addr == PIN_A_ENABLES_OFFSET) begin
        pin_a_irq_enables_reg <= reg_wdata;
      end
      if (reg_addr == PIN_B_ENABLES_OFFSET) begin
        pin_b_irq_enables_reg <= reg_wdata;
      end
    end
  end

  // count write becomes a one-cycle load request to the countdown unit
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      countdown_repeat_select_reg <= CD_REPEAT_RESET;
      countdown_step_select_reg   <= CD_STEP_RESET;
      load_value_reg              <= CD_COUNT_RESET;
      load_req_reg                <= 1'b0;
    end else begin
      load_req_reg <= 1'b0;
      if (reg_wr && reg_addr == COUNTDOWN_OFFSET) begin
        countdown_repeat_select_reg <= reg_wdata[CD_REPEAT_BIT];
        countdown_step_select_reg   <= reg_wdata[CD_STEP_MSB:CD_STEP_LSB];
        load_value_reg              <= reg_wdata[CD_COUNT_MSB:CD_COUNT_LSB];
        load_req_reg                <= 1'b1;
      end
    end
  end

  // read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      if (is_alarm_addr(reg_addr)) begin
        reg_rdata_reg <= alarm_byte_reg[3'(reg_addr - ALARM_FIRST_OFFSET)];
      end else begin
        case (reg_addr)
          ALARM_ENABLES_OFFSET: reg_rdata_reg <= alarm_field_enables_reg;
          PIN_A_ENABLES_OFFSET: reg_rdata_reg <= pin_a_irq_enables_reg;
          PIN_B_ENABLES_OFFSET: reg_rdata_reg <= pin_b_irq_enables_reg;
          // live counter, not the written value; it keeps running meanwhile
          COUNTDOWN_OFFSET:     reg_rdata_reg <= {countdown_repeat_select_reg, cd.count,
                                                  countdown_step_select_reg};
          default:              reg_rdata_reg <= 8'h00;
        endcase
      end
    end
  end

  assign reg_rdata = reg_rdata_reg;

  // matches judged only on an increment, so writing an alarm byte cannot set a flag
  assign alarm1_hit = time_inc && elapsed_time_mode_select
                   && |alarm_field_enables_reg[ALM1_TOP_HOURS_BIT:ALM1_SECONDS_BIT]
                   && field_ok(alarm_field_enables_reg[ALM1_SECONDS_BIT],   alarm_byte_reg[0], time_sec,
                               SEC_MIN_MASK)
                   && field_ok(alarm_field_enables_reg[ALM1_MINUTES_BIT],   alarm_byte_reg[1], time_min,
                               SEC_MIN_MASK)
                   && field_ok(alarm_field_enables_reg[ALM1_LOW_HOURS_BIT], alarm_byte_reg[2], time_hr_low,
                               HOURS_MASK)
                   && field_ok(alarm_field_enables_reg[ALM1_MID_HOURS_BIT], alarm_byte_reg[3], time_hr_mid,
                               HOURS_MASK)
                   && field_ok(alarm_field_enables_reg[ALM1_TOP_HOURS_BIT], alarm_byte_reg[4], time_hr_top,
                               HOURS_MASK);

  assign alarm2_hit = time_inc && elapsed_time_mode_select
                   && |alarm_field_enables_reg[ALM2_UPPER_HOURS_BIT:ALM2_MINUTES_BIT]
                   && field_ok(alarm_field_enables_reg[ALM2_MINUTES_BIT],     alarm_byte_reg[5], time_min,
                               SEC_MIN_MASK)
                   && field_ok(alarm_field_enables_reg[ALM2_LOWER_HOURS_BIT], alarm_byte_reg[6], time_hr_low,
                               HOURS_MASK)
                   && field_ok(alarm_field_enables_reg[ALM2_UPPER_HOURS_BIT], alarm_byte_reg[7], time_hr_mid,
                               HOURS_MASK);

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      first_alarm_flag_reg  <= 1'b0;
      second_alarm_flag_reg <= 1'b0;
    end else begin
      first_alarm_flag_reg  <= alarm1_hit || (first_alarm_flag_reg && !alarm1_flag_clear);
      second_alarm_flag_reg <= alarm2_hit || (second_alarm_flag_reg && !alarm2_flag_clear);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      countdown_expired_flag_reg <= 1'b0;
    end else begin
      countdown_expired_flag_reg <= cd.expire || (countdown_expired_flag_reg && !countdown_flag_clear);
    end
  end

  assign first_alarm_flag       = first_alarm_flag_reg;
  assign second_alarm_flag      = second_alarm_flag_reg;
  assign countdown_expired_flag = countdown_expired_flag_reg;

  // interrupt pins, active low
  assign events   = {alarm1_hit, alarm2_hit, cd.expire};
  assign flags    = {first_alarm_flag_reg, second_alarm_flag_reg, countdown_expired_flag_reg};
  assign pin_a_en = {pin_a_irq_enables_reg[IRQ_ALARM1_BIT], pin_a_irq_enables_reg[IRQ_ALARM2_BIT],
                     pin_a_irq_enables_reg[IRQ_COUNTDOWN_BIT]};
  assign pin_b_en = {pin_b_irq_enables_reg[IRQ_ALARM1_BIT], pin_b_irq_enables_reg[IRQ_ALARM2_BIT],
                     pin_b_irq_enables_reg[IRQ_COUNTDOWN_BIT]};

  // pulse mode ignores the flags, so an uncleared flag still gets a new pulse
  assign irq_pin_a_n_next = irq_level_n(pin_a_pulse_mode, events, flags, pin_a_en);
  assign irq_pin_b_n_next = irq_level_n(pin_b_pulse_mode, events, flags, pin_b_en);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_pin_a_n_reg <= 1'b1;
      irq_pin_b_n_reg <= 1'b1;
    end else begin
      irq_pin_a_n_reg <= irq_pin_a_n_next;
      irq_pin_b_n_reg <= irq_pin_b_n_next;
    end
  end

  assign irq_pin_a_n = irq_pin_a_n_reg;
  assign irq_pin_b_n = irq_pin_b_n_reg;

  sequence s_alarm1_match;
    alarm1_hit;
  endsequence

  sequence s_flag1_held;
    first_alarm_flag_reg && !alarm1_flag_clear && !alarm1_hit;
  endsequence

  a_alarm1_sets: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_alarm1_match |=> first_alarm_flag)
    else $error("alarm 1 match did not set its flag");

  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_flag1_held |=> first_alarm_flag ##1 (first_alarm_flag || $past(alarm1_flag_clear)))
    else $error("alarm 1 flag dropped without clear");

  a_flag2_cause: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(second_alarm_flag) |-> $past(time_inc) && $past(elapsed_time_mode_select))
    else $error("alarm 2 flag set without a time increment");

  a_disabled_ignored: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (alarm_field_enables_reg[ALM1_SECONDS_BIT] == 1'b0 && alarm1_hit) |->
      (alarm_byte_reg[1][6:0] == time_min[6:0] || !alarm_field_enables_reg[ALM1_MINUTES_BIT]))
    else $error("alarm 1 matched with an enabled field differing");

  a_pulse_repeats: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (pin_a_pulse_mode && alarm1_hit && pin_a_irq_enables_reg[IRQ_ALARM1_BIT]) |=> !irq_pin_a_n)
    else $error("pin a missed a pulse on alarm 1 match");

  a_level_follows: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!pin_b_pulse_mode && pin_b_irq_enables_reg[IRQ_COUNTDOWN_BIT] && countdown_expired_flag_reg)
      |=> !irq_pin_b_n)
    else $error("pin b level does not follow countdown flag");

  a_countdown_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cd.expire |=> countdown_expired_flag ##1 (countdown_expired_flag || $past(countdown_flag_clear)))
    else $error("countdown expiry not flagged");

  a_read_live: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == COUNTDOWN_OFFSET) |=> (reg_rdata[CD_COUNT_MSB:CD_COUNT_LSB] == $past(cd.count)))
    else $error("countdown read is not the live count");

  a_write_loads: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == COUNTDOWN_OFFSET) |=> (cd.load_req && cd.load_value == $past(reg_wdata[6:2])))
    else $error("countdown write not passed to the unit");

  sequence s_alarm2_match;
    alarm2_hit;
  endsequence

  a_alarm2_sets: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_alarm2_match |=> second_alarm_flag)
    else $error("alarm 2 match did not set its flag");

  a_flag1_cause: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(first_alarm_flag) |-> $past(time_inc) && $past(elapsed_time_mode_select))
    else $error("alarm 1 flag set without a time increment");

  a_mode_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !elapsed_time_mode_select |-> (!alarm1_hit && !alarm2_hit))
    else $error("alarm matched outside elapsed-time mode");

  a_masked_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (pin_a_irq_enables_reg[IRQ_ALARM1_BIT:IRQ_COUNTDOWN_BIT] == 3'h0)
      |=> irq_pin_a_n)
    else $error("pin a asserted with all its enables off");

  a_level_drops: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!pin_a_pulse_mode && ((flags & pin_a_en) == 3'h0))
      |=> irq_pin_a_n)
    else $error("pin a level held without an enabled flag");

  a_pulse_single: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (pin_b_pulse_mode && ((events & pin_b_en) == 3'h0))
      |=> irq_pin_b_n)
    else $error("pin b pulse without an enabled event");

endmodule // stopwatch_alarm_watchdog

// *** bench/host_model.sv ***
`timescale 1ns/1ps
module host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = v;
    reg_wr    = 1'b1;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~v; // released data must not look valid
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge ref_clk);
    reg_rd   = 1'b0;
    v        = reg_rdata;
  endtask
  // the counter cannot be frozen, so reads repeat in pairs until two agree, giving up after 8 pairs
  task automatic rd_stable(input logic [7:0] a, output logic [7:0] v);
    logic [7:0] v2;
    v2 = 8'h00;
    v  = 8'hff;
    for (int i = 0; i < 8 && v !== v2; i++) begin
      rd(a, v);
      rd(a, v2);
    end
  endtask
endmodule // host_model

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  import stopwatch_pkg::*;
  logic       ref_clk, rst_b, osc, mode, tinc, clr1, clr2, clrc, pa, pb;
  logic [7:0] sec, mn, hl, hm, ht, d, addr, wdata, rdata;
  logic       wr, rd, f1, f2, fc, ia_n, ib_n;
  int         err_total, total_checks, p;
  host_model host (.ref_clk(ref_clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));
  stopwatch_alarm_watchdog DUT (
    .ref_clk(ref_clk), .rst_b(rst_b), .osc_clk_pin(osc), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .elapsed_time_mode_select(mode), .time_inc(tinc),
    .time_sec(sec), .time_min(mn), .time_hr_low(hl), .time_hr_mid(hm), .time_hr_top(ht),
    .alarm1_flag_clear(clr1), .alarm2_flag_clear(clr2), .countdown_flag_clear(clrc),
    .pin_a_pulse_mode(pa), .pin_b_pulse_mode(pb), .first_alarm_flag(f1), .second_alarm_flag(f2),
    .countdown_expired_flag(fc), .irq_pin_a_n(ia_n), .irq_pin_b_n(ib_n));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // fast oscillator, phase unrelated to ref_clk
  initial begin
    osc = 1'b0;
    #7;
    forever #30 osc = ~osc;
  end
  task automatic complete_run;
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(input logic [7:0] s, input logic [7:0] m);
    @(negedge ref_clk);
    sec  = s;
    mn   = m;
    tinc = 1'b1;
    @(negedge ref_clk);
    tinc = 1'b0;
  endtask
  task automatic clear_all;
    @(negedge ref_clk);
    {clr1, clr2, clrc} = 3'h7;
    @(negedge ref_clk);
    {clr1, clr2, clrc} = 3'h0;
    @(negedge ref_clk);
  endtask
  task automatic wait_cd(output int n);
    n = 0;
    while (fc !== 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n > 30000) begin
        err_total++;
        complete_run();
      end
    end
  endtask
  task automatic t_reset;
    `CHK("irq a", 1'b1, ia_n)
    host.rd(ALARM_ENABLES_OFFSET, d);
    `CHK("enables", 8'h00, d)
    host.rd(COUNTDOWN_OFFSET, d);
    `CHK("countdown", 8'h00, d)
    host.wr(8'h3f, 8'h5a);
    host.rd(8'h3f, d);
    `CHK("unmapped", 8'h00, d)
    host.wr(ALARM_ENABLES_OFFSET, 8'ha5);
    host.rd(ALARM_ENABLES_OFFSET, d);
    `CHK("enables rw", 8'ha5, d)
  endtask
  task automatic t_alarm1;
    sec = 8'h30;
    host.wr(8'h08, 8'h30);
    host.wr(8'h0a, 8'h12);
    host.wr(ALARM_ENABLES_OFFSET, 8'h05);
    host.wr(PIN_A_ENABLES_OFFSET, 8'h10);
    `CHK("static", 1'b0, f1)
    hl = 8'h13;
    tick(8'h30, 8'h00);
    `CHK("wrong hour", 1'b0, f1)
    hl = 8'h12;
    mode = 1'b0;
    tick(8'h30, 8'h00);
    `CHK("clock mode", 1'b0, f1)
    mode = 1'b1;
    tick(8'h30, 8'h59);
    `CHK("a1 flag", 1'b1, f1)
    // level pin follows the registered flag one cycle later
    @(negedge ref_clk);
    `CHK("a1 level", 1'b0, ia_n)
    tick(8'h31, 8'h59);
    `CHK("a1 sticky", 1'b1, f1)
    clear_all();
    `CHK("a1 clr", 1'b0, f1)
    `CHK("a1 irq off", 1'b1, ia_n)
    tick(8'h30, 8'h01);
    `CHK("a1 again", 1'b1, f1)
  endtask
  task automatic t_alarm2;
    pa = 1'b1;
    pb = 1'b1;
    host.wr(8'h0d, 8'h15);
    host.wr(8'h09, 8'h15);
    host.wr(8'h0e, 8'h12);
    host.wr(PIN_B_ENABLES_OFFSET, 8'h08);
    // alarm 2 on all its fields, alarm 1 on minutes only with seconds left out
    host.wr(ALARM_ENABLES_OFFSET, 8'he2);
    tick(8'h00, 8'h15);
    `CHK("a2 flag", 1'b1, f2)
    `CHK("a2 pulse", 1'b0, ib_n)
    `CHK("a1 pulse", 1'b0, ia_n)
    @(negedge ref_clk);
    `CHK("a2 pulse end", 1'b1, ib_n)
    `CHK("a1 pulse end", 1'b1, ia_n)
    tick(8'h01, 8'h15);
    `CHK("a2 repeat", 1'b0, ib_n)
    `CHK("a1 repeat", 1'b0, ia_n)
  endtask
  task automatic t_countdown;
    pa = 1'b0;
    pb = 1'b0;
    host.wr(PIN_A_ENABLES_OFFSET, 8'h04);
    host.wr(PIN_B_ENABLES_OFFSET, 8'h04);
    repeat (3) @(negedge ref_clk);
    `CHK("a1 masked", 1'b1, ia_n)
    clear_all();
    host.wr(COUNTDOWN_OFFSET, 8'h14);
    repeat (20) @(negedge ref_clk);
    host.rd_stable(COUNTDOWN_OFFSET, d);
    `CHK("live count", 8'h14, d)
    host.wr(COUNTDOWN_OFFSET, 8'h07);
    wait_cd(p);
    @(negedge ref_clk);
    `CHK("cd irq", 1'b0, ia_n)
    `CHK("cd irq b", 1'b0, ib_n)
    `CHK("reload fast", 1'b1, p < 13000)
    repeat (13000) @(negedge ref_clk);
    host.rd(COUNTDOWN_OFFSET, d);
    `CHK("halt zero", 8'h03, d)
    clear_all();
    pb = 1'b1;
    host.wr(COUNTDOWN_OFFSET, 8'h87);
    wait_cd(p);
    `CHK("cd pulse", 1'b0, ib_n)
    @(negedge ref_clk);
    `CHK("cd pulse end", 1'b1, ib_n)
    clear_all();
    wait_cd(p);
    // one sixteenth second is 2048 osc periods of 60 ns
    `CHK("period", 1'b1, (p + 3 >= 12284) && (p + 3 <= 12292))
    host.wr(COUNTDOWN_OFFSET, 8'h00);
    clear_all();
    repeat (14000) @(negedge ref_clk);
    `CHK("stopped", 1'b0, fc)
    host.wr(COUNTDOWN_OFFSET, 8'h82);
    host.rd(COUNTDOWN_OFFSET, d);
    `CHK("step field", 8'h82, d)
  endtask
  initial begin
    {rst_b, tinc, clr1, clr2, clrc, pa, pb} = 7'h00;
    mode = 1'b1;
    {sec, mn, hm, ht} = 32'h0;
    hl = 8'h12;
    err_total = 0;
    total_checks = 0;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    t_reset();
    t_alarm1();
    t_alarm2();
    t_countdown();
    complete_run();
  end
endmodule // testbench
